/* src/rsg_defines.vh */
// Constants for the reset supervisor and write guard block
`ifndef RSG_DEFINES_VH
`define RSG_DEFINES_VH

// ==========================================================
// Timing
// ==========================================================
`define RSG_CLK_KHZ 125000
`define RSG_TIMEOUT_MS 200
`define RSG_TIMEOUT_CYC (`RSG_TIMEOUT_MS * `RSG_CLK_KHZ)
`define RSG_WRITE_MS 5
`define RSG_WRITE_CYC (`RSG_WRITE_MS * `RSG_CLK_KHZ)
`define RSG_DEBOUNCE_US 10
`define RSG_DEBOUNCE_CYC 11'h04E2
`define RSG_PIN_BLANK 4'h4

// ==========================================================
// Serial bus
// ==========================================================
`define RSG_DEV_ADDR 7'h50
`define RSG_ST_IDLE 3'h0
`define RSG_ST_DEVA 3'h1
`define RSG_ST_ADDR 3'h2
`define RSG_ST_WDAT 3'h3
`define RSG_ST_RDAT 3'h4

`endif

/* src/rsg_supervisor.v */
// Reset supervisor with debounced manual reset and guarded serial memory
`timescale 1ns/1ns
`default_nettype none
`include "rsg_defines.vh"

module rsg_supervisor #(
    parameter TIMEOUT_CYC = `RSG_TIMEOUT_CYC, // Reset hold, cycles
    parameter WRITE_CYC = `RSG_WRITE_CYC // Internal write time, cycles
) (
    input wire clk_i,
    input wire resetn_i,
    input wire supply_good_i,
    input wire manual_reset_request_n_i,
    input wire write_protect_i,
    input wire rst_n_pin_i,
    output reg rst_n_pin_o,
    output reg rst_n_pin_oe_o,
    output reg rst_hi_o,
    output reg rst_hi_oe_o,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    reg [5:0] sync_a; // First stage, read only by second stage
    reg [5:0] sync_b; // Second stage, safe to use
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            // Supply reads bad until really sampled, so no write slips through
            sync_a <= 6'h3A;
            sync_b <= 6'h3A;
        end else begin
            sync_a <= {sda_i, scl_i, rst_n_pin_i, write_protect_i,
                       manual_reset_request_n_i, supply_good_i};
            sync_b <= sync_a;
        end
    end
    wire sup_s = sync_b[0]; // Supply good
    wire mr_s = sync_b[1]; // Manual request, low active
    wire wp_s = sync_b[2]; // Write protect
    wire pin_s = sync_b[3]; // Reset pin readback
    wire scl_s = sync_b[4];
    wire sda_s = sync_b[5];

    // ==========================================================
    // Manual request debounce
    // ==========================================================
    reg mr_db; // Debounced level, idle high
    reg [10:0] dcnt; // Stable-mismatch counter
    // Level must differ for the whole window before it is taken
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            mr_db <= 1'b1;
            dcnt <= 11'h0000;
        end else if (mr_s == mr_db) begin
            dcnt <= 11'h0000; // Bounce restarts the window
        end else if (dcnt == `RSG_DEBOUNCE_CYC - 11'h0001) begin
            mr_db <= mr_s; // Stable long enough
            dcnt <= 11'h0000;
        end else begin
            dcnt <= dcnt + 11'h0001;
        end
    end

    // ==========================================================
    // Reset state and timeout
    // ==========================================================
    reg asserted; // Reset currently driven
    reg [24:0] tcnt; // Timeout counter
    reg [3:0] blank; // Ignores own pin echo after release
    // Our own low drive returns through the pin synchroniser; without
    // masking and a short blank window the block would hold itself.
    wire pin_ext = !pin_s && !asserted && (blank == 4'h0);
    wire cause = !sup_s || !mr_db || pin_ext;

    // Any cause clears the counter, release after full timeout
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            asserted <= 1'b1;
            tcnt <= 25'h000_0000;
            blank <= 4'h0;
        end else begin
            if (blank != 4'h0) begin
                blank <= blank - 4'h1;
            end
            if (cause) begin
                asserted <= 1'b1;
                tcnt <= 25'h000_0000;
            end else if (asserted) begin
                if (tcnt == TIMEOUT_CYC[24:0] - 25'h000_0001) begin
                    asserted <= 1'b0;
                    blank <= `RSG_PIN_BLANK;
                end else begin
                    tcnt <= tcnt + 25'h000_0001;
                end
            end
        end
    end

    // Open-drain outputs: only enables move
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            rst_n_pin_o <= 1'b0;
            rst_hi_o <= 1'b1;
            rst_n_pin_oe_o <= 1'b1;
            rst_hi_oe_o <= 1'b1;
            sda_o <= 1'b0;
        end else begin
            rst_n_pin_o <= 1'b0;
            rst_hi_o <= 1'b1;
            rst_n_pin_oe_o <= cause || asserted;
            rst_hi_oe_o <= cause || asserted;
            sda_o <= 1'b0; // Never drives high
        end
    end

    // ==========================================================
    // Serial bus edge detection
    // ==========================================================
    reg scl_q;
    reg sda_q;
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end
    wire bus_start = scl_s && sda_q && !sda_s;
    wire bus_stop = scl_s && !sda_q && sda_s;
    wire scl_rise = scl_s && !scl_q;
    wire scl_fall = !scl_s && scl_q;

    // ==========================================================
    // Array, page buffer and bus state
    // ==========================================================
    reg [7:0] mem [0:255]; // 2k-bit array, not reset
    reg [7:0] pbuf [0:15]; // Page buffer
    reg [15:0] pvld; // Bytes loaded into page buffer
    reg [2:0] st; // Bus state
    reg ackp; // In acknowledge bit
    reg [3:0] cnt; // Bit counter
    reg [7:0] sh; // Shift register
    reg [7:0] ptr; // Word address
    reg [19:0] bcnt; // Write cycle countdown
    reg commit; // One-cycle page commit
    wire busy = bcnt != 20'h0_0000;
    // Guard sampled at the stop that ends the write
    wire wr_ok = !wp_s && sup_s;
    integer i;

    // Byte-level bus slave; host keeps the clock slow enough for the
    // two-flop sampling to see every edge
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            st <= `RSG_ST_IDLE;
            ackp <= 1'b0;
            cnt <= 4'h0;
            sh <= 8'h00;
            ptr <= 8'h00;
            pvld <= 16'h0000;
            sda_oe_o <= 1'b0;
            commit <= 1'b0;
        end else begin
            commit <= 1'b0;
            if (bus_start) begin
                st <= `RSG_ST_DEVA;
                ackp <= 1'b0;
                cnt <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (bus_stop) begin
                // Commit only when guards allow
                commit <= (st == `RSG_ST_WDAT) && (pvld != 16'h0000) && wr_ok;
                st <= `RSG_ST_IDLE;
                ackp <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (scl_rise) begin
                if (st == `RSG_ST_RDAT) begin
                    if (ackp && sda_s) begin
                        st <= `RSG_ST_IDLE; // Host did not acknowledge
                    end
                end else if (!ackp && st != `RSG_ST_IDLE) begin
                    sh <= {sh[6:0], sda_s};
                    cnt <= cnt + 4'h1;
                end
            end else if (scl_fall) begin
                if (ackp) begin
                    // End of acknowledge bit
                    ackp <= 1'b0;
                    cnt <= 4'h0;
                    if (st == `RSG_ST_RDAT) begin
                        sh <= mem[ptr];
                        sda_oe_o <= !mem[ptr][7];
                        ptr <= ptr + 8'h01;
                    end else begin
                        sda_oe_o <= 1'b0;
                    end
                end else if (st == `RSG_ST_RDAT) begin
                    if (cnt == 4'h7) begin
                        sda_oe_o <= 1'b0; // Release for host answer
                        ackp <= 1'b1;
                    end else begin
                        sh <= {sh[6:0], 1'b0};
                        sda_oe_o <= !sh[6];
                        cnt <= cnt + 4'h1;
                    end
                end else if (cnt == 4'h8) begin
                    ackp <= 1'b1;
                    sda_oe_o <= 1'b1; // Acknowledge by pulling low
                    case (st)
                        `RSG_ST_DEVA: begin
                            // No answer while a write cycle runs
                            if (sh[7:1] == `RSG_DEV_ADDR && !busy) begin
                                st <= sh[0] ? `RSG_ST_RDAT : `RSG_ST_ADDR;
                            end else begin
                                st <= `RSG_ST_IDLE;
                                ackp <= 1'b0;
                                sda_oe_o <= 1'b0;
                            end
                        end
                        `RSG_ST_ADDR: begin
                            ptr <= sh;
                            pvld <= 16'h0000;
                            st <= `RSG_ST_WDAT;
                        end
                        `RSG_ST_WDAT: begin
                            // Low bits wrap inside the page
                            pbuf[ptr[3:0]] <= sh;
                            pvld[ptr[3:0]] <= 1'b1;
                            ptr <= {ptr[7:4], ptr[3:0] + 4'h1};
                        end
                        default: begin
                            st <= `RSG_ST_IDLE;
                            ackp <= 1'b0;
                            sda_oe_o <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // Internal write cycle
    // ==========================================================
    // Array updated at commit, busy window bounds the write
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            bcnt <= 20'h0_0000;
        end else if (commit) begin
            bcnt <= WRITE_CYC[19:0];
        end else if (busy) begin
            bcnt <= bcnt - 20'h0_0001;
        end
    end

    // Copy loaded bytes of the page into the array
    always @(posedge clk_i) begin
        if (commit) begin
            for (i = 0; i < 16; i = i + 1) begin
                if (pvld[i]) begin
                    mem[{ptr[7:4], i[3:0]}] <= pbuf[i];
                end
            end
        end
    end

endmodule // rsg_supervisor
`default_nettype wire

/* verif/rsg_host.sv */
// Two-wire bus host model driving the serial clock and data lines
`timescale 1ns/1ns
`default_nettype none
module rsg_host (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
// ==========================================
// Bit timing
localparam int Q = 80; // Quarter bit: 320 clocks a bit, 390 kHz
initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0; // Only ever pulls low
end
task automatic q_step(input logic s, input logic l);
    repeat (Q) @(posedge clk_i);
    scl_o <= s;
    sda_low_o <= l;
endtask
task automatic start;
    q_step(1'b0, 1'b0);
    q_step(1'b1, 1'b0);
    q_step(1'b1, 1'b1); // Data falls while clock high
    q_step(1'b0, 1'b1);
endtask
task automatic stop;
    q_step(1'b0, 1'b1);
    q_step(1'b1, 1'b1);
    q_step(1'b1, 1'b0); // Data rises while clock high
endtask
task automatic bitx(input logic b, output logic r);
    q_step(1'b0, !b); // Data moves only while clock low
    q_step(1'b1, !b);
    repeat (Q) @(posedge clk_i);
    r = sda_i;
    q_step(1'b0, !b);
endtask
task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]); // Most significant bit first
    bitx(a, r); // Ninth bit: acknowledge
endtask
endmodule // rsg_host
`default_nettype wire

/* verif/rsg_supervisor_sva.sv */
// Assertion checker for the reset supervisor outputs and open-drain levels
`timescale 1ns/1ns
`default_nettype none
module rsg_supervisor_sva #(
    parameter int TIMEOUT_CYC = 200
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic supply_good_i,
    input wire logic manual_reset_request_n_i,
    input wire logic write_protect_i,
    input wire logic rst_n_pin_i,
    input wire logic rst_n_pin_o,
    input wire logic rst_n_pin_oe_o,
    input wire logic rst_hi_o,
    input wire logic rst_hi_oe_o,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o
);
// ==========================================
// Helper counters
default clocking @(posedge clk_i); endclocking
default disable iff (!resetn_i);
logic [31:0] clean_cnt; // Cycles with every outside cause clear
logic [11:0] low_cnt; // Cycles of manual request held low
always @(posedge clk_i) begin
    // Our own low drive on the pin is not a cause; only a low while released counts
    if (!resetn_i || !supply_good_i || !manual_reset_request_n_i ||
        (!rst_n_pin_i && !rst_n_pin_oe_o)) begin
        clean_cnt <= 32'h0000_0000;
    end else begin
        clean_cnt <= clean_cnt + 32'h0000_0001;
    end
    low_cnt <= manual_reset_request_n_i ? 12'h000 : low_cnt + {11'h000, low_cnt != 12'hFFF};
end
// Pin pulled low from outside while the block is not driving it
sequence pin_forced;
    !rst_n_pin_oe_o [*6] ##1 !rst_n_pin_i [*3];
endsequence
pair_same_a: assert property (rst_n_pin_oe_o == rst_hi_oe_o)
    else $error("reset enables differ");
drive_level_a: assert property (!sda_o && !rst_n_pin_o && rst_hi_o)
    else $error("open-drain level wrong");
supply_rst_a: assert property (!supply_good_i [*5] |-> rst_n_pin_oe_o)
    else $error("no reset on bad supply");
supply_hold_a: assert property ($rose(supply_good_i) |-> rst_n_pin_oe_o [*8])
    else $error("reset dropped at supply return");
manual_rst_a: assert property (low_cnt == 12'd1300 |-> rst_n_pin_oe_o)
    else $error("no reset on manual request");
pin_rst_a: assert property (pin_forced |-> ##[0:6] rst_n_pin_oe_o)
    else $error("forced pin ignored");
min_hold_a: assert property ($fell(rst_n_pin_oe_o) |-> clean_cnt >= TIMEOUT_CYC)
    else $error("reset released early");
max_hold_a: assert property (clean_cnt == TIMEOUT_CYC + 1300 |-> !rst_n_pin_oe_o)
    else $error("reset held too long");
endmodule // rsg_supervisor_sva
bind rsg_supervisor rsg_supervisor_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) sva_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .supply_good_i(supply_good_i),
    .manual_reset_request_n_i(manual_reset_request_n_i), .write_protect_i(write_protect_i),
    .rst_n_pin_i(rst_n_pin_i), .rst_n_pin_o(rst_n_pin_o), .rst_n_pin_oe_o(rst_n_pin_oe_o),
    .rst_hi_o(rst_hi_o), .rst_hi_oe_o(rst_hi_oe_o), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o));
`default_nettype wire

/* verif/rsg_supervisor_tb.sv */
// Self-checking bench for the reset supervisor and write guard
`timescale 1ns/1ns
`default_nettype none
`include "rsg_defines.vh"
module rsg_supervisor_tb;
// ==========================================
// Stimulus and pulled wires
localparam int TO = 200; // Shortened reset hold
localparam int WC = 3200; // Write time, outlasts one address byte
localparam logic [7:0] DEV = {`RSG_DEV_ADDR, 1'b0}; // Write address byte
logic clk_i = 1'b0, resetn_i = 1'b0, supply_good_i = 1'b0, manual_n = 1'b1;
logic wp = 1'b0, force_low = 1'b0, k;
logic scl, host_low, rn_o, rn_oe, rh_o, rh_oe, sd_o, sd_oe;
logic [7:0] q;
wire logic rst_n_wire = (rn_oe ? rn_o : 1'b1) && !force_low; // Pull-up
wire logic rst_hi_wire = rh_oe ? rh_o : 1'b0; // Pull-down
wire logic sda_wire = !host_low && (sd_oe ? sd_o : 1'b1); // Pull-up
int mismatches = 0, num_checks = 0, cyc = 0;
always #4 clk_i = ~clk_i;
rsg_supervisor #(.TIMEOUT_CYC(TO), .WRITE_CYC(WC)) uut (
    .clk_i(clk_i), .resetn_i(resetn_i), .supply_good_i(supply_good_i),
    .manual_reset_request_n_i(manual_n), .write_protect_i(wp), .rst_n_pin_i(rst_n_wire),
    .rst_n_pin_o(rn_o), .rst_n_pin_oe_o(rn_oe), .rst_hi_o(rh_o), .rst_hi_oe_o(rh_oe),
    .scl_i(scl), .sda_i(sda_wire), .sda_o(sd_o), .sda_oe_o(sd_oe));
rsg_host host (.clk_i(clk_i), .sda_i(sda_wire), .scl_o(scl), .sda_low_o(host_low));
task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
endtask
task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
        mismatches++;
        $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
endtask
task automatic rst_is(input string n, input logic e);
    check(n, 8'(rst_hi_wire), 8'(e));
    check(n, 8'(!rst_n_wire), 8'(e));
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic two, output logic n);
    logic r0, r1, r2, r3;
    r3 = 1'b0;
    host.start();
    host.xfer(DEV, 1'b1, q, r0);
    host.xfer(a, 1'b1, q, r1);
    host.xfer(d, 1'b1, q, r2);
    if (two) host.xfer(8'hAA, 1'b1, q, r3); // Second byte wraps in the page
    host.stop();
    n = r0 | r1 | r2 | r3;
endtask
task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic r;
    host.start();
    host.xfer(DEV, 1'b1, q, r);
    host.xfer(a, 1'b1, q, r);
    host.start();
    host.xfer(DEV | 8'h01, 1'b1, q, r);
    host.xfer(8'hFF, 1'b1, d, r); // Last byte not acknowledged
    host.stop();
endtask
task automatic t_supply;
    tick(10);
    rst_is("supply low", 1'b1);
    supply_good_i <= 1'b1;
    tick(TO - 10);
    rst_is("supply hold", 1'b1);
    supply_good_i <= 1'b0;
    tick(10);
    supply_good_i <= 1'b1;
    tick(TO - 5);
    rst_is("restart", 1'b1);
    tick(20);
    rst_is("released", 1'b0);
    $display("supply test done");
endtask
task automatic t_manual;
    manual_n <= 1'b0;
    tick(100);
    manual_n <= 1'b1;
    tick(1400);
    rst_is("bounce", 1'b0);
    manual_n <= 1'b0;
    tick(1400);
    rst_is("manual", 1'b1);
    manual_n <= 1'b1;
    tick(1220 + TO);
    rst_is("manual hold", 1'b1);
    tick(80);
    rst_is("manual end", 1'b0);
    $display("manual test done");
endtask
task automatic t_pin;
    force_low <= 1'b1;
    tick(10);
    force_low <= 1'b0;
    tick(20);
    rst_is("pin", 1'b1);
    tick(TO + 20);
    rst_is("pin end", 1'b0);
    $display("pin test done");
endtask
task automatic t_mem;
    wr(8'hFF, 8'h55, 1'b1, k);
    check("page ack", 8'(k), 8'h00);
    tick(20);
    host.start();
    host.xfer(DEV, 1'b1, q, k);
    host.stop();
    check("busy nack", 8'(k), 8'h01);
    tick(WC);
    wp <= 1'b1;
    wr(8'hF0, 8'h01, 1'b0, k);
    check("ready ack", 8'(k), 8'h00);
    tick(10);
    wp <= 1'b0;
    tick(WC);
    supply_good_i <= 1'b0;
    wr(8'hFF, 8'h02, 1'b0, k);
    tick(10);
    supply_good_i <= 1'b1;
    tick(WC + TO + 40);
    rd(8'hF0, q);
    check("protected", q, 8'hAA);
    rd(8'hFF, q);
    check("supply guard", q, 8'h55);
    $display("memory test done");
endtask
task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
        $display("TEST PASSED");
    end else begin
        $display("TEST FAILED");
    end
    $finish;
endtask
// Hang guard, well past the planned run
always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
        mismatches++;
        summarize();
    end
end
initial begin
    tick(6);
    resetn_i <= 1'b1;
    tick(3);
    t_supply();
    t_manual();
    t_pin();
    t_mem();
    summarize();
end
endmodule // rsg_supervisor_tb
`default_nettype wire
